// [rtl/mvsel_pkg.sv]
package mvsel_pkg;
	localparam int MV_W = 12;
	typedef logic signed [MV_W-1:0] mvsel_mv_t;
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_MV_HI     = 8'h04;
	localparam logic [7:0] ADDR_MV_LO     = 8'h08;
	localparam logic [7:0] ADDR_MV_MAN    = 8'h0c;
	localparam logic [7:0] ADDR_MV_RST    = 8'h10;
	localparam logic [7:0] ADDR_MV_ERR    = 8'h14;
	localparam logic [7:0] ADDR_FIX_SP    = 8'h18;
	localparam logic [7:0] ADDR_STATUS    = 8'h1c;
	localparam logic [7:0] ADDR_MV_OUT    = 8'h20;
	localparam int CTRL_FOLLOW   = 0;
	localparam int CTRL_FIXMODE  = 1;
	localparam int CTRL_MANLIM   = 2;
	localparam int CTRL_HEATCOOL = 3;
	localparam int CTRL_POSPROP  = 4;
	localparam int CTRL_DIRECT   = 5;
	localparam int CTRL_CLOSECTL = 6;
	localparam int CTRL_W        = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
	localparam mvsel_mv_t MV_STD_MIN = -12'sd50;
	localparam mvsel_mv_t MV_HC_MIN  = -12'sd1050;
	localparam mvsel_mv_t MV_MAX     = 12'sd1050;
	localparam mvsel_mv_t MV_ZERO    = 12'sd0;
	localparam mvsel_mv_t MV_FULL    = 12'sd1000;
	localparam mvsel_mv_t HI_RESET   = 12'sd1000;
	localparam mvsel_mv_t LO_RESET   = 12'sd0;
	localparam int SP_W = 16;
	localparam logic [1:0] VALVE_HOLD = 2'h0;
	localparam logic [1:0] VALVE_OPEN = 2'h1;
	localparam logic [1:0] VALVE_SHUT = 2'h2;
	typedef enum logic [1:0] {
		MVSEL_SRC_CALC = 2'b00,
		MVSEL_SRC_ERR  = 2'b01,
		MVSEL_SRC_RST  = 2'b11,
		MVSEL_SRC_MAN  = 2'b10
	} mvsel_src_t;
endpackage : mvsel_pkg

// [rtl/mvsel_clamp.sv]
`timescale 1ns/10ps
module mvsel_clamp (
	// Value and limits.
	input  wire mvsel_pkg::mvsel_mv_t value,
	input  wire mvsel_pkg::mvsel_mv_t lim_lo,
	input  wire mvsel_pkg::mvsel_mv_t lim_hi,
	// Result.
	output mvsel_pkg::mvsel_mv_t      clamped
);
	import mvsel_pkg::*;
	always_comb begin
		if (value > lim_hi) begin
			clamped = lim_hi;
		end else if (value < lim_lo) begin
			clamped = lim_lo;
		end else begin
			clamped = value;
		end
	end
endmodule : mvsel_clamp

// [rtl/mvsel_valve.sv]
`timescale 1ns/10ps
module mvsel_valve (
	// Override value and mode.
	input  wire mvsel_pkg::mvsel_mv_t mv,
	input  wire logic                 direct,
	input  wire logic                 pot_err,
	input  wire mvsel_pkg::mvsel_mv_t opening,
	// Open and close drive.
	output logic                      open_on,
	output logic                      shut_on
);
	import mvsel_pkg::*;
	always_comb begin
		open_on = 1'b0;
		shut_on = 1'b0;
		if (!direct) begin
			open_on = (mv[1:0] == VALVE_OPEN);
			shut_on = (mv[1:0] == VALVE_SHUT);
		end else if (pot_err) begin
			open_on = (mv >= MV_FULL);
			shut_on = (mv <= MV_ZERO);
		end else begin
			open_on = (opening < mv);
			shut_on = (opening > mv);
		end
	end
endmodule : mvsel_valve

// [rtl/mvsel_top.sv]
`timescale 1ns/10ps
// Functional notes
// - Program to fixed with follow copies setpoint
// - No copy going fixed to program
// - Follow works only when enabled; off
// - Program time runs in manual, errors
// - Initial level halts program, outputs off
// - Calculated MV clamped to limits
// - Overrides unclamped except limited manual
// - Manual limit restricts manual MV range
// - One limit pair for heat/cool
// - Heat/cool sign picks side, +-105.0
// - Standard overrides -5.0..105.0, default 0.0
// - Enumerated override: open, shut, hold
// - Direct valve target opening, default 0.0
// - Priority manual, reset, then error
// - Pot error: reset MV thresholds valve
// - Pot error: error MV thresholds valve
// - Input error substitutes error MV
// - Setpoint source defaults to program
module mvsel_top (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	// Register port.
	input  wire logic [7:0]             reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic [31:0]                 reg_rdata,
	// Controller state.
	input  wire mvsel_pkg::mvsel_mv_t   calc_mv,
	input  wire logic [15:0]            program_sp,
	input  wire logic                   manual_mode,
	input  wire logic                   reset_state,
	input  wire logic                   input_err,
	input  wire logic                   pot_err,
	input  wire mvsel_pkg::mvsel_mv_t   valve_opening,
	input  wire logic                   init_level,
	input  wire logic                   program_run_req,
	input  wire logic                   time_tick,
	// Outputs.
	output mvsel_pkg::mvsel_mv_t        mv_out,
	output logic                        heat_on,
	output logic                        cool_on,
	output logic                        ctrl_out1,
	output logic                        ctrl_out2,
	output logic                        program_running,
	output logic                        program_time_adv,
	output logic                        aux_outputs_off,
	output logic [15:0]                 fixed_sp
);
	import mvsel_pkg::*;

	logic [CTRL_W-1:0] ctrl_r;
	mvsel_mv_t         hi_r;
	mvsel_mv_t         lo_r;
	mvsel_mv_t         man_r;
	mvsel_mv_t         rst_mv_r;
	mvsel_mv_t         err_mv_r;
	logic [SP_W-1:0]   fix_sp_r;
	logic              fix_mode_d_r;
	mvsel_mv_t         mv_r;
	mvsel_mv_t         mv_nxt;
	logic              out1_r;
	logic              out2_r;
	logic              out1_nxt;
	logic              out2_nxt;
	logic              run_r;
	logic              adv_r;
	mvsel_src_t        src;
	mvsel_mv_t         calc_cl;
	mvsel_mv_t         man_cl;
	mvsel_mv_t         ovr_mv;
	mvsel_mv_t         wmv;
	mvsel_mv_t         ovr_min;
	logic              pv_err;
	logic              v_open;
	logic              v_shut;
	logic              posprop;
	logic              to_fixed;

	assign wmv      = mvsel_mv_t'(reg_wdata[MV_W-1:0]);
	assign ovr_min  = ctrl_r[CTRL_HEATCOOL] ? MV_HC_MIN : MV_STD_MIN;
	assign posprop  = ctrl_r[CTRL_POSPROP];
	assign pv_err   = input_err | (pot_err & ctrl_r[CTRL_CLOSECTL]);
	assign to_fixed = ctrl_r[CTRL_FIXMODE] & ~fix_mode_d_r;

	// Control word holds follow enable, source select and mode bits.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_r <= CTRL_RESET;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			ctrl_r <= reg_wdata[CTRL_W-1:0];
		end
	end

	// Limit and override values; out-of-range writes are ignored.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hi_r     <= HI_RESET;
			lo_r     <= LO_RESET;
			man_r    <= MV_ZERO;
			rst_mv_r <= MV_ZERO;
			err_mv_r <= MV_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_MV_HI: begin
					if (wmv <= MV_MAX && wmv >= ovr_min) hi_r <= wmv;
				end
				ADDR_MV_LO: begin
					if (wmv <= MV_MAX && wmv >= ovr_min) lo_r <= wmv;
				end
				ADDR_MV_MAN: begin
					if (wmv <= MV_MAX && wmv >= ovr_min) man_r <= wmv;
				end
				ADDR_MV_RST: begin
					if (wmv <= MV_MAX && wmv >= ovr_min) rst_mv_r <= wmv;
				end
				ADDR_MV_ERR: begin
					if (wmv <= MV_MAX && wmv >= ovr_min) err_mv_r <= wmv;
				end
				default: begin
				end
			endcase
		end
	end

	// Fixed setpoint follows program setpoint on a program-to-fixed switch when follow is enabled.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fix_mode_d_r <= 1'b0;
		end else begin
			fix_mode_d_r <= ctrl_r[CTRL_FIXMODE];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fix_sp_r <= '0;
		end else if (to_fixed && ctrl_r[CTRL_FOLLOW]) begin
			fix_sp_r <= program_sp;
		end else if (reg_wr && reg_addr == ADDR_FIX_SP) begin
			fix_sp_r <= reg_wdata[SP_W-1:0];
		end
	end

	mvsel_clamp u_calc_clamp (
		.value   (calc_mv),
		.lim_lo  (lo_r),
		.lim_hi  (hi_r),
		.clamped (calc_cl)
	);

	mvsel_clamp u_man_clamp (
		.value   (man_r),
		.lim_lo  (lo_r),
		.lim_hi  (hi_r),
		.clamped (man_cl)
	);

	// Source priority: manual, reset, error, calculated.
	always_comb begin
		if (manual_mode) begin
			src = MVSEL_SRC_MAN;
		end else if (reset_state) begin
			src = MVSEL_SRC_RST;
		end else if (pv_err) begin
			src = MVSEL_SRC_ERR;
		end else begin
			src = MVSEL_SRC_CALC;
		end
	end

	always_comb begin
		case (src)
			MVSEL_SRC_MAN:  ovr_mv = ctrl_r[CTRL_MANLIM] ? man_cl : man_r;
			MVSEL_SRC_RST:  ovr_mv = rst_mv_r;
			MVSEL_SRC_ERR:  ovr_mv = err_mv_r;
			default:        ovr_mv = calc_cl;
		endcase
	end

	mvsel_valve u_valve (
		.mv      (ovr_mv),
		.direct  (ctrl_r[CTRL_DIRECT]),
		.pot_err (pot_err),
		.opening (valve_opening),
		.open_on (v_open),
		.shut_on (v_shut)
	);

	always_comb begin
		mv_nxt   = ovr_mv;
		out1_nxt = 1'b0;
		out2_nxt = 1'b0;
		if (init_level) begin
			mv_nxt = MV_ZERO;
		end else if (posprop) begin
			out1_nxt = v_open;
			out2_nxt = v_shut;
		end else begin
			out1_nxt = ovr_mv > MV_ZERO;
			out2_nxt = ctrl_r[CTRL_HEATCOOL] && ovr_mv < MV_ZERO;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mv_r   <= MV_ZERO;
			out1_r <= 1'b0;
			out2_r <= 1'b0;
		end else begin
			mv_r   <= mv_nxt;
			out1_r <= out1_nxt;
			out2_r <= out2_nxt;
		end
	end

	// Program run and time progression; errors and manual do not pause it.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			run_r <= 1'b0;
			adv_r <= 1'b0;
		end else begin
			run_r <= program_run_req & ~init_level;
			adv_r <= program_run_req & ~init_level & time_tick;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_CTRL:   reg_rdata <= {25'h0, ctrl_r};
				ADDR_MV_HI:  reg_rdata <= {{20{hi_r[MV_W-1]}}, hi_r};
				ADDR_MV_LO:  reg_rdata <= {{20{lo_r[MV_W-1]}}, lo_r};
				ADDR_MV_MAN: reg_rdata <= {{20{man_r[MV_W-1]}}, man_r};
				ADDR_MV_RST: reg_rdata <= {{20{rst_mv_r[MV_W-1]}}, rst_mv_r};
				ADDR_MV_ERR: reg_rdata <= {{20{err_mv_r[MV_W-1]}}, err_mv_r};
				ADDR_FIX_SP: reg_rdata <= {16'h0, fix_sp_r};
				ADDR_STATUS: reg_rdata <= {26'h0, src, out2_r, out1_r, run_r, pv_err};
				ADDR_MV_OUT: reg_rdata <= {{20{mv_r[MV_W-1]}}, mv_r};
				default:     reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	assign mv_out           = mv_r;
	assign ctrl_out1        = out1_r;
	assign ctrl_out2        = out2_r;
	assign heat_on          = out1_r & ~posprop;
	assign cool_on          = out2_r & ~posprop;
	assign program_running  = run_r;
	assign program_time_adv = adv_r;
	assign aux_outputs_off  = init_level;
	assign fixed_sp         = fix_sp_r;

	follow_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
		(to_fixed && ctrl_r[CTRL_FOLLOW]) |=> fix_sp_r == $past(program_sp))
		else $error("fixed setpoint not copied");
	no_back_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!ctrl_r[CTRL_FIXMODE] && !(reg_wr && reg_addr == ADDR_FIX_SP)) |=> $stable(fix_sp_r))
		else $error("fixed setpoint changed in program mode");
	init_off_a: assert property (@(posedge clk) disable iff (!rst_b)
		init_level |=> (!out1_r && !out2_r && !run_r && mv_r == MV_ZERO))
		else $error("outputs live at initial level");
	calc_clamp_a: assert property (@(posedge clk) disable iff (!rst_b)
		(src == MVSEL_SRC_CALC && !init_level && lo_r <= hi_r) |=>
		(mv_r <= $past(hi_r) && mv_r >= $past(lo_r)))
		else $error("calculated MV out of limits");
	rst_bypass_a: assert property (@(posedge clk) disable iff (!rst_b)
		(src == MVSEL_SRC_RST && !init_level) |=> mv_r == $past(rst_mv_r))
		else $error("reset MV not passed through");
	man_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
		(manual_mode && ctrl_r[CTRL_MANLIM] && !init_level && lo_r <= hi_r) |=>
		(mv_r <= $past(hi_r) && mv_r >= $past(lo_r)))
		else $error("manual MV not limited");
	priority_a: assert property (@(posedge clk) disable iff (!rst_b)
		(manual_mode && !ctrl_r[CTRL_MANLIM] && !init_level) |=> mv_r == $past(man_r))
		else $error("manual MV lost priority");
	err_subst_a: assert property (@(posedge clk) disable iff (!rst_b)
		(pv_err && !manual_mode && !reset_state && !init_level) |=> mv_r == $past(err_mv_r))
		else $error("error MV not substituted");
	pot_valve_a: assert property (@(posedge clk) disable iff (!rst_b)
		(posprop && ctrl_r[CTRL_DIRECT] && pot_err && !init_level && ovr_mv >= MV_FULL)
		|=> (out1_r && !out2_r))
		else $error("open output missing on pot error");
	time_run_a: assert property (@(posedge clk) disable iff (!rst_b)
		(program_run_req && time_tick && !init_level) |=> adv_r)
		else $error("program time stalled");
	pot_shut_a: assert property (@(posedge clk) disable iff (!rst_b)
		(posprop && ctrl_r[CTRL_DIRECT] && pot_err && !init_level && ovr_mv <= MV_ZERO)
		|=> (!out1_r && out2_r))
		else $error("close output missing on pot error");
	pot_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(posprop && ctrl_r[CTRL_DIRECT] && pot_err && !init_level &&
		ovr_mv > MV_ZERO && ovr_mv < MV_FULL) |=> (!out1_r && !out2_r))
		else $error("valve not held on pot error");
	enum_open_a: assert property (@(posedge clk) disable iff (!rst_b)
		(posprop && !ctrl_r[CTRL_DIRECT] && !init_level && ovr_mv[1:0] == VALVE_OPEN)
		|=> (out1_r && !out2_r))
		else $error("open choice not driven");
	enum_shut_a: assert property (@(posedge clk) disable iff (!rst_b)
		(posprop && !ctrl_r[CTRL_DIRECT] && !init_level && ovr_mv[1:0] == VALVE_SHUT)
		|=> (!out1_r && out2_r))
		else $error("shut choice not driven");
	enum_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(posprop && !ctrl_r[CTRL_DIRECT] && !init_level && ovr_mv[1:0] == VALVE_HOLD)
		|=> (!out1_r && !out2_r))
		else $error("hold choice not driven");
	direct_open_a: assert property (@(posedge clk) disable iff (!rst_b)
		(posprop && ctrl_r[CTRL_DIRECT] && !pot_err && !init_level && valve_opening < ovr_mv)
		|=> (out1_r && !out2_r))
		else $error("valve not opened toward target");
	direct_shut_a: assert property (@(posedge clk) disable iff (!rst_b)
		(posprop && ctrl_r[CTRL_DIRECT] && !pot_err && !init_level && valve_opening > ovr_mv)
		|=> (!out1_r && out2_r))
		else $error("valve not closed toward target");
	heat_side_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!posprop && !init_level && ovr_mv > MV_ZERO) |=> (out1_r && !out2_r))
		else $error("heating side not driven");
	cool_side_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!posprop && ctrl_r[CTRL_HEATCOOL] && !init_level && ovr_mv < MV_ZERO)
		|=> (!out1_r && out2_r))
		else $error("cooling side not driven");
	follow_off_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!ctrl_r[CTRL_FOLLOW] && !(reg_wr && reg_addr == ADDR_FIX_SP)) |=> $stable(fix_sp_r))
		else $error("fixed setpoint copied with follow off");
	time_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
		init_level |=> !adv_r)
		else $error("program time ran at initial level");
	follow_cov: cover property (@(posedge clk) disable iff (!rst_b)
		to_fixed && ctrl_r[CTRL_FOLLOW]);
	man_cov: cover property (@(posedge clk) disable iff (!rst_b)
		manual_mode && reset_state && pv_err);
	pot_cov: cover property (@(posedge clk) disable iff (!rst_b)
		posprop && ctrl_r[CTRL_DIRECT] && pot_err && reset_state);
	valve_cov: cover property (@(posedge clk) disable iff (!rst_b)
		posprop && !ctrl_r[CTRL_DIRECT] && ovr_mv[1:0] == VALVE_SHUT);
	init_cov: cover property (@(posedge clk) disable iff (!rst_b)
		init_level && program_run_req);
endmodule : mvsel_top

// [testbench/mvsel_valve_model.sv]
`timescale 1ns/10ps
// Valve driven by the open and close outputs; opening moves one step per cycle.
module mvsel_valve_model (
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               rst_b,
	// Drive from the block.
	input  wire logic               open_on,
	input  wire logic               shut_on,
	// Potentiometer reading.
	output mvsel_pkg::mvsel_mv_t    opening
);
	import mvsel_pkg::*;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			opening <= MV_ZERO;
		end else if (open_on && !shut_on && opening < MV_FULL) begin
			opening <= opening + 12'sd1;
		end else if (shut_on && !open_on && opening > MV_ZERO) begin
			opening <= opening - 12'sd1;
		end
	end
endmodule : mvsel_valve_model

// [testbench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	import mvsel_pkg::*;
	logic        clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, manual_mode = 0;
	logic        reset_state = 0, input_err = 0, pot_err = 0, init_level = 0;
	logic        program_run_req = 0, time_tick = 0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
	logic [15:0] program_sp = 16'h0, fixed_sp;
	mvsel_mv_t   calc_mv = 12'sd0, mv_out, valve_opening;
	logic        heat_on, cool_on, ctrl_out1, ctrl_out2, program_running;
	logic        program_time_adv, aux_outputs_off;
	int          err_count = 0, n_tests = 0, cyc = 0;
	always #50 clk = ~clk;
	mvsel_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .calc_mv(calc_mv),
		.program_sp(program_sp), .manual_mode(manual_mode), .reset_state(reset_state),
		.input_err(input_err), .pot_err(pot_err), .valve_opening(valve_opening),
		.init_level(init_level), .program_run_req(program_run_req), .time_tick(time_tick),
		.mv_out(mv_out), .heat_on(heat_on), .cool_on(cool_on), .ctrl_out1(ctrl_out1),
		.ctrl_out2(ctrl_out2), .program_running(program_running),
		.program_time_adv(program_time_adv), .aux_outputs_off(aux_outputs_off),
		.fixed_sp(fixed_sp));
	mvsel_valve_model valve (.clk(clk), .rst_b(rst_b), .open_on(ctrl_out1),
		.shut_on(ctrl_out2), .opening(valve_opening));
	task conclude;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask : rd
	task settle;
		repeat (2) @(posedge clk);
	endtask : settle
	task t_reset;
		rd(ADDR_CTRL, d); chk(d, 32'h0);
		rd(ADDR_MV_HI, d); chk(d, 32'd1000);
		rd(ADDR_MV_LO, d); chk(d, 32'd0);
		rd(ADDR_MV_RST, d); chk(d, 32'd0);
		rd(ADDR_MV_ERR, d); chk(d, 32'd0);
	endtask : t_reset
	task t_clamp;
		wr(ADDR_MV_HI, 32'd900);
		wr(ADDR_MV_LO, 32'd100);
		calc_mv <= 12'sd1000;
		settle(); chk(mv_out, 12'sd900);
		calc_mv <= 12'sd50;
		settle(); chk(mv_out, 12'sd100);
	endtask : t_clamp
	task t_override;
		wr(ADDR_MV_MAN, 32'd1020);
		wr(ADDR_MV_RST, -32'sd30);
		wr(ADDR_MV_ERR, 32'd40);
		wr(ADDR_MV_RST, -32'sd60);
		rd(ADDR_MV_RST, d); chk(d, -32'sd30);
		manual_mode <= 1'b1;
		reset_state <= 1'b1;
		input_err <= 1'b1;
		settle(); chk(mv_out, 12'sd1020);
		wr(ADDR_CTRL, 32'h4);
		settle(); chk(mv_out, 12'sd900);
		manual_mode <= 1'b0;
		settle(); chk(mv_out, -12'sd30);
		reset_state <= 1'b0;
		settle(); chk(mv_out, 12'sd40);
		input_err <= 1'b0;
		wr(ADDR_CTRL, 32'h0);
	endtask : t_override
	task t_follow;
		program_sp <= 16'h1234;
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_CTRL, 32'h3);
		settle(); chk(fixed_sp, 16'h1234);
		program_sp <= 16'h5678;
		wr(ADDR_CTRL, 32'h1);
		settle(); chk(fixed_sp, 16'h1234);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_CTRL, 32'h2);
		settle(); chk(fixed_sp, 16'h1234);
	endtask : t_follow
	task t_heatcool;
		wr(ADDR_CTRL, 32'h8);
		wr(ADDR_MV_RST, -32'sd500);
		reset_state <= 1'b1;
		settle(); chk({heat_on, cool_on}, 2'b01);
		wr(ADDR_MV_RST, 32'd500);
		settle(); chk({heat_on, cool_on}, 2'b10);
		reset_state <= 1'b0;
		calc_mv <= -12'sd1000;
		wr(ADDR_MV_LO, -32'sd500);
		settle();
		chk(mv_out, -12'sd500);
		chk({heat_on, cool_on}, 2'b01);
	endtask : t_heatcool
	task t_valve;
		logic [1:0] exp_out [3];
		exp_out = '{2'b00, 2'b10, 2'b01};
		wr(ADDR_CTRL, 32'h10);
		reset_state <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_MV_RST, 32'(i));
			settle(); chk({ctrl_out1, ctrl_out2}, exp_out[i]);
		end
		reset_state <= 1'b0;
		wr(ADDR_CTRL, 32'h0);
	endtask : t_valve
	task t_direct;
		wr(ADDR_CTRL, 32'h70);
		wr(ADDR_MV_RST, 32'd0);
		reset_state <= 1'b1;
		for (int i = 0; i < 1100 && valve_opening != 12'sd0; i++) begin
			@(posedge clk);
		end
		settle();
		chk(valve_opening, 32'h0);
		chk({ctrl_out1, ctrl_out2}, 2'b00);
		wr(ADDR_MV_RST, 32'd500);
		settle();
		chk({ctrl_out1, ctrl_out2}, 2'b10);
		pot_err <= 1'b1;
		wr(ADDR_MV_RST, 32'd1000);
		settle();
		chk({ctrl_out1, ctrl_out2}, 2'b10);
		wr(ADDR_MV_RST, 32'd500);
		settle();
		chk({ctrl_out1, ctrl_out2}, 2'b00);
		wr(ADDR_MV_RST, 32'd0);
		settle();
		chk({ctrl_out1, ctrl_out2}, 2'b01);
		reset_state <= 1'b0;
		settle();
		chk(mv_out, 12'sd40);
		chk({ctrl_out1, ctrl_out2}, 2'b00);
		wr(ADDR_MV_ERR, 32'd1050);
		settle();
		chk({ctrl_out1, ctrl_out2}, 2'b10);
		wr(ADDR_MV_ERR, -32'sd50);
		settle();
		chk({ctrl_out1, ctrl_out2}, 2'b01);
		chk(mv_out, -12'sd50);
		pot_err <= 1'b0;
		wr(ADDR_CTRL, 32'h0);
	endtask : t_direct
	task t_init;
		calc_mv <= 12'sd500;
		program_run_req <= 1'b1;
		manual_mode <= 1'b1;
		input_err <= 1'b1;
		@(posedge clk);
		time_tick <= 1'b1;
		@(posedge clk);
		time_tick <= 1'b0;
		@(posedge clk);
		chk(program_time_adv, 1'b1);
		chk(program_running, 1'b1);
		init_level <= 1'b1;
		settle(); chk(mv_out, 12'sd0);
		chk({ctrl_out1, program_running, aux_outputs_off}, 3'b001);
	endtask : t_init
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_clamp();
		t_override();
		t_follow();
		t_heatcool();
		t_valve();
		t_direct();
		t_init();
		conclude();
	end
endmodule : tb_top
